// File: src/jca_defines.svh
`ifndef JCA_DEFINES_SVH
`define JCA_DEFINES_SVH

`define JCA_CLK_MHZ         200
`define JCA_BOOT_NS         1000
`define JCA_BOOT_CYC        ((`JCA_BOOT_NS * `JCA_CLK_MHZ + 999) / 1000)
`define JCA_SYNC_DEPTH      3
`define JCA_NUM_WAIT        4
`define JCA_NUM_OUT         4
`define JCA_OP_W            3
`define JCA_OP_NOP          3'h0
`define JCA_OP_OPEN         3'h1
`define JCA_OP_CLOSE        3'h2
`define JCA_OP_WAIT_START   3'h3
`define JCA_OP_WAIT_IN      3'h4
`define JCA_OP_OUTPUT_SET   3'h5
`define JCA_OP_MARK_ON      3'h6
`define JCA_OP_MARK_OFF     3'h7
`define JCA_OUT_RESET       4'h0

`endif

// File: src/jca_pkg.sv
package jca_pkg;
  typedef enum logic [3:0] {
    JCA_IDLE    = 4'b0001,
    JCA_RUN     = 4'b0010,
    JCA_WAIT_ST = 4'b0100,
    JCA_WAIT_IN = 4'b1000
  } jca_state_t;
endpackage : jca_pkg

// File: src/jca_sync.sv
`timescale 1ns/1ps
`default_nettype none
module jca_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } jca_sync_t;
  jca_sync_t st_reg;
  jca_sync_t st_next;

  // Only the second stage reads the first
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.q;
endmodule : jca_sync
`default_nettype wire

// File: src/jca_quad.sv
`timescale 1ns/1ps
`default_nettype none
module jca_quad #(
  parameter int CW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          phase_a,
  input  wire logic          phase_b,
  output logic      [CW-1:0] count
);
  typedef struct packed {
    logic          a;
    logic          b;
    logic [CW-1:0] cnt;
  } jca_quad_t;
  jca_quad_t st_reg;
  jca_quad_t st_next;

  // Inputs are already synchronised; a double-phase jump is ignored
  always_comb begin
    st_next   = st_reg;
    st_next.a = phase_a;
    st_next.b = phase_b;
    if ((phase_a ^ st_reg.a) && !(phase_b ^ st_reg.b)) begin
      st_next.cnt = (phase_a ^ phase_b) ? st_reg.cnt + 1'b1 : st_reg.cnt - 1'b1;
    end else if ((phase_b ^ st_reg.b) && !(phase_a ^ st_reg.a)) begin
      st_next.cnt = (phase_a ^ phase_b) ? st_reg.cnt - 1'b1 : st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.cnt;
endmodule : jca_quad
`default_nettype wire

// File: src/jca_aux_io.sv
// How it works
// - Wait-start instruction stalls until start input
// - Wait-input instruction stalls until named input
// - Low isolated reset forces full soft reset
// - Abort input ends job, back to idle
// - Error/ready low once boot completes
// - Error/ready high during boot and exceptions
// - Job-active high while job open, waiting too
// - Busy set on open, cleared on close
// - Marking high while marking, cleared on close
// - Output-set instruction drives four job outputs
// - Two quadrature encoder channels are received
// - Stepper link: transmit pair out, receive in
`timescale 1ns/1ps
`default_nettype none
`include "jca_defines.svh"
module jca_aux_io
  import jca_pkg::*;
#(
  parameter int BOOT_CYC = `JCA_BOOT_CYC,
  parameter int ENC_W    = 32
) (
  input  wire logic                    CLOCK,
  input  wire logic                    RESET_N,
  input  wire logic                    ISO_START_IN,
  input  wire logic                    ISO_RESET_IN_N,
  input  wire logic                    ISO_ABORT_IN,
  input  wire logic                    ISO_WAIT_IN_1,
  input  wire logic                    ISO_WAIT_IN_2,
  input  wire logic                    ISO_WAIT_IN_3,
  input  wire logic                    ISO_WAIT_IN_4,
  input  wire logic                    HW_EXCEPTION,
  input  wire logic                    INSTR_VALID,
  input  wire logic [`JCA_OP_W-1:0]    INSTR_OP,
  input  wire logic [1:0]              INSTR_SEL,
  input  wire logic [`JCA_NUM_OUT-1:0] INSTR_DATA,
  output logic                         INSTR_READY,
  output logic                         SOFT_RESET_OUT,
  output logic                         ERROR_READY_OUT_N,
  output logic                         JOB_ACTIVE_OUT,
  output logic                         BUSY_OUT,
  output logic                         MARKING_ACTIVE_OUT,
  output logic                         JOB_OUT_1,
  output logic                         JOB_OUT_2,
  output logic                         JOB_OUT_3,
  output logic                         JOB_OUT_4,
  input  wire logic                    ENC0_PHASE_A_P,
  input  wire logic                    ENC0_PHASE_B_P,
  input  wire logic                    ENC1_PHASE_A_P,
  input  wire logic                    ENC1_PHASE_B_P,
  output logic [ENC_W-1:0]             ENC0_COUNT,
  output logic [ENC_W-1:0]             ENC1_COUNT,
  input  wire logic                    STEPPER_TX_DATA,
  output logic                         STEPPER_LINK_TX_P,
  output logic                         STEPPER_LINK_TX_N,
  input  wire logic                    STEPPER_LINK_RX_P,
  output logic                         STEPPER_RX_DATA
);
  localparam int BW = $clog2(BOOT_CYC + 1);

  initial begin
    if (BOOT_CYC < 1 || ENC_W < 2) begin
      $error("jca_aux_io: bad parameters");
    end
  end

  typedef struct packed {
    jca_state_t               state;
    logic [BW-1:0]            boot_cnt;
    logic                     booted;
    logic                     soft_rst;
    logic                     instr_ready;
    logic                     err_ready_n;
    logic                     job_active;
    logic                     busy;
    logic                     marking;
    logic [`JCA_NUM_OUT-1:0]  outs;
    logic [1:0]               wait_sel;
    logic                     tx;
    logic                     rx;
  } jca_top_t;

  jca_top_t st_reg;
  jca_top_t st_next;

  logic [8:0]              sync_out;
  logic                    start_s;
  logic                    rst_iso_n_s;
  logic                    abort_s;
  logic [`JCA_NUM_WAIT-1:0] wait_s;
  logic [3:0]              enc_s;

  // Isolated inputs come from outside the clock domain
  jca_sync #(.W(9)) u_sync_ctl (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .din   ({STEPPER_LINK_RX_P, ISO_WAIT_IN_4, ISO_WAIT_IN_3, ISO_WAIT_IN_2,
             ISO_WAIT_IN_1, ISO_ABORT_IN, ~ISO_RESET_IN_N, ISO_START_IN, 1'b0}),
    .dout  (sync_out)
  );

  jca_sync #(.W(4)) u_sync_enc (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .din   ({ENC1_PHASE_B_P, ENC1_PHASE_A_P, ENC0_PHASE_B_P, ENC0_PHASE_A_P}),
    .dout  (enc_s)
  );

  assign start_s     = sync_out[1];
  assign rst_iso_n_s = ~sync_out[2];
  assign abort_s     = sync_out[3];
  assign wait_s      = sync_out[7:4];

  // Counters are flops inside the decoders
  jca_quad #(.CW(ENC_W)) u_enc0 (
    .clk     (CLOCK),
    .rst_n   (RESET_N),
    .phase_a (enc_s[0]),
    .phase_b (enc_s[1]),
    .count   (ENC0_COUNT)
  );

  jca_quad #(.CW(ENC_W)) u_enc1 (
    .clk     (CLOCK),
    .rst_n   (RESET_N),
    .phase_a (enc_s[2]),
    .phase_b (enc_s[3]),
    .count   (ENC1_COUNT)
  );

  function automatic logic job_clear(input jca_top_t s);
    return 1'b0;
  endfunction : job_clear

  always_comb begin
    st_next          = st_reg;
    st_next.tx       = STEPPER_TX_DATA;
    st_next.rx       = sync_out[8];
    st_next.soft_rst = !rst_iso_n_s;
    if (!st_reg.booted) begin
      if (st_reg.boot_cnt == BW'(BOOT_CYC - 1)) begin
        st_next.booted = 1'b1;
      end else begin
        st_next.boot_cnt = st_reg.boot_cnt + 1'b1;
      end
    end
    // Exception wins over ready so a fault is never hidden
    st_next.err_ready_n = !st_next.booted || HW_EXCEPTION;
    st_next.instr_ready = 1'b0;
    if (!rst_iso_n_s) begin
      // Soft reset reboots; outputs also return to reset level
      st_next             = '0;
      st_next.state       = JCA_IDLE;
      st_next.err_ready_n = 1'b1;
      st_next.soft_rst    = 1'b1;
      st_next.outs        = `JCA_OUT_RESET;
      st_next.tx          = STEPPER_TX_DATA;
      st_next.rx          = sync_out[8];
    end else if (abort_s) begin
      st_next.state      = JCA_IDLE;
      st_next.job_active = 1'b0;
      st_next.busy       = 1'b0;
      st_next.marking    = 1'b0;
    end else if (st_reg.booted) begin
      case (st_reg.state)
        JCA_WAIT_ST: begin
          if (start_s) begin
            st_next.state = JCA_RUN;
          end
        end
        JCA_WAIT_IN: begin
          if (wait_s[st_reg.wait_sel]) begin
            st_next.state = JCA_RUN;
          end
        end
        JCA_IDLE, JCA_RUN: begin
          st_next.instr_ready = 1'b1;
          if (INSTR_VALID && st_reg.instr_ready) begin
            // At least one idle cycle after each take keeps the source paced
            st_next.instr_ready = 1'b0;
            case (INSTR_OP)
              `JCA_OP_OPEN: begin
                st_next.state      = JCA_RUN;
                st_next.busy       = 1'b1;
                st_next.job_active = 1'b1;
              end
              `JCA_OP_CLOSE: begin
                st_next.state      = JCA_IDLE;
                st_next.busy       = 1'b0;
                st_next.job_active = 1'b0;
                st_next.marking    = 1'b0;
              end
              `JCA_OP_WAIT_START: begin
                if (st_reg.state == JCA_RUN) begin
                  st_next.state       = JCA_WAIT_ST;
                  st_next.instr_ready = 1'b0;
                end
              end
              `JCA_OP_WAIT_IN: begin
                if (st_reg.state == JCA_RUN) begin
                  st_next.state       = JCA_WAIT_IN;
                  st_next.wait_sel    = INSTR_SEL;
                  st_next.instr_ready = 1'b0;
                end
              end
              `JCA_OP_OUTPUT_SET: begin
                // Only honoured inside a job
                if (st_reg.state == JCA_RUN) begin
                  st_next.outs = INSTR_DATA;
                end
              end
              `JCA_OP_MARK_ON: begin
                if (st_reg.state == JCA_RUN) begin
                  st_next.marking = 1'b1;
                end
              end
              `JCA_OP_MARK_OFF: begin
                st_next.marking = 1'b0;
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
          st_next.state = JCA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      st_reg             <= '0;
      st_reg.state       <= JCA_IDLE;
      st_reg.err_ready_n <= 1'b1;
      st_reg.outs        <= `JCA_OUT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign INSTR_READY        = st_reg.instr_ready;
  assign SOFT_RESET_OUT     = st_reg.soft_rst;
  assign ERROR_READY_OUT_N  = st_reg.err_ready_n;
  assign JOB_ACTIVE_OUT     = st_reg.job_active;
  assign BUSY_OUT           = st_reg.busy;
  assign MARKING_ACTIVE_OUT = st_reg.marking;
  assign JOB_OUT_1          = st_reg.outs[0];
  assign JOB_OUT_2          = st_reg.outs[1];
  assign JOB_OUT_3          = st_reg.outs[2];
  assign JOB_OUT_4          = st_reg.outs[3];
  // Pair is driven complementary from one flop
  assign STEPPER_LINK_TX_P  = st_reg.tx;
  assign STEPPER_LINK_TX_N  = ~st_reg.tx;
  assign STEPPER_RX_DATA    = st_reg.rx;
endmodule : jca_aux_io
`default_nettype wire

// File: verif/jca_aux_io_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "jca_defines.svh"
module jca_chk #(
  parameter int BOOT_CYC = 4
) (
  input wire logic                 CLOCK,
  input wire logic                 RESET_N,
  input wire logic                 ISO_START_IN,
  input wire logic                 ISO_ABORT_IN,
  input wire logic                 HW_EXCEPTION,
  input wire logic                 INSTR_VALID,
  input wire logic [`JCA_OP_W-1:0] INSTR_OP,
  input wire logic                 INSTR_READY,
  input wire logic                 SOFT_RESET_OUT,
  input wire logic                 ERROR_READY_OUT_N,
  input wire logic                 JOB_ACTIVE_OUT,
  input wire logic                 BUSY_OUT,
  input wire logic                 MARKING_ACTIVE_OUT,
  input wire logic                 STEPPER_TX_DATA,
  input wire logic                 STEPPER_LINK_TX_P,
  input wire logic                 STEPPER_LINK_TX_N
);
  logic       take;
  logic [7:0] age_reg;
  assign take = INSTR_VALID && INSTR_READY;
  // Saturates so a long run never looks like boot again
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) age_reg <= 8'h00;
    else if (age_reg != 8'hff) age_reg <= age_reg + 8'h01;
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  chk_open_sets_job: assert property (take && INSTR_OP == `JCA_OP_OPEN
    |=> BUSY_OUT && JOB_ACTIVE_OUT) else $error("open missed");
  chk_close_clears: assert property (take && INSTR_OP == `JCA_OP_CLOSE
    |=> !BUSY_OUT && !MARKING_ACTIVE_OUT && !JOB_ACTIVE_OUT) else $error("close missed");
  chk_ready_gap: assert property (take |=> !INSTR_READY) else $error("no ready gap");
  chk_boot_err: assert property (age_reg < BOOT_CYC |-> ERROR_READY_OUT_N)
    else $error("ready too soon");
  chk_boot_done: assert property (age_reg == BOOT_CYC + 3 && !HW_EXCEPTION
    && !$past(HW_EXCEPTION) |-> !ERROR_READY_OUT_N) else $error("boot too long");
  chk_exc_err: assert property (HW_EXCEPTION |=> ERROR_READY_OUT_N) else $error("no error");
  chk_soft_clear: assert property (SOFT_RESET_OUT |=> !BUSY_OUT && !JOB_ACTIVE_OUT
    && !MARKING_ACTIVE_OUT && !INSTR_READY && ERROR_READY_OUT_N) else $error("soft left state");
  chk_abort_clear: assert property (ISO_ABORT_IN [*6] |-> !BUSY_OUT
    && !JOB_ACTIVE_OUT && !MARKING_ACTIVE_OUT) else $error("abort left job");
  chk_job_levels: assert property (BUSY_OUT || MARKING_ACTIVE_OUT |-> JOB_ACTIVE_OUT)
    else $error("job inactive");
  chk_wait_start: assert property (!ISO_START_IN [*4] ##0 (take && JOB_ACTIVE_OUT
    && INSTR_OP == `JCA_OP_WAIT_START) |=> !INSTR_READY [*2]) else $error("no stall");
  chk_tx_pair: assert property ($past(RESET_N) && !SOFT_RESET_OUT && !$past(SOFT_RESET_OUT)
    |-> STEPPER_LINK_TX_P == $past(STEPPER_TX_DATA) && STEPPER_LINK_TX_N == !STEPPER_LINK_TX_P)
    else $error("tx pair wrong");
  cover property (take && INSTR_OP == `JCA_OP_CLOSE);
  cover property (ISO_ABORT_IN && BUSY_OUT);
  cover property ($rose(SOFT_RESET_OUT));
endmodule : jca_chk
bind jca_aux_io jca_chk #(.BOOT_CYC(BOOT_CYC)) u_chk (.CLOCK(CLOCK), .RESET_N(RESET_N),
  .ISO_START_IN(ISO_START_IN), .ISO_ABORT_IN(ISO_ABORT_IN), .HW_EXCEPTION(HW_EXCEPTION),
  .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP), .INSTR_READY(INSTR_READY),
  .SOFT_RESET_OUT(SOFT_RESET_OUT), .ERROR_READY_OUT_N(ERROR_READY_OUT_N),
  .JOB_ACTIVE_OUT(JOB_ACTIVE_OUT), .BUSY_OUT(BUSY_OUT), .MARKING_ACTIVE_OUT(MARKING_ACTIVE_OUT),
  .STEPPER_TX_DATA(STEPPER_TX_DATA), .STEPPER_LINK_TX_P(STEPPER_LINK_TX_P),
  .STEPPER_LINK_TX_N(STEPPER_LINK_TX_N));
`default_nettype wire

// File: verif/jca_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module jca_far_end (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic tx_p,
  input  wire logic tx_n,
  output logic      rx_p,
  output logic      enc0_a,
  output logic      enc0_b,
  output logic      enc1_a,
  output logic      enc1_b
);
  logic [3:0] div_reg = 4'h0;
  initial rx_p = 1'h0;
  // Broken pair gives a toggling line, not a stale copy
  always @(posedge clk) begin
    rx_p <= (tx_p !== tx_n) ? tx_p : ~rx_p;
    if (run) div_reg <= div_reg + 4'h1;
  end
  // Gray steps; channel 1 runs backwards
  assign enc0_a = div_reg[3] ^ div_reg[2];
  assign enc0_b = div_reg[3];
  assign enc1_a = div_reg[3];
  assign enc1_b = div_reg[3] ^ div_reg[2];
endmodule : jca_far_end
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "jca_defines.svh"
module testbench;
  logic        clk = 1'h0, rst_n = 1'h0, st = 1'h0, srn = 1'h1, ab = 1'h0, exc = 1'h0;
  logic        v = 1'h0, txd = 1'h0, run = 1'h0, rdy, sro, err_n, ja, bsy, mk;
  logic        tp, tn, rp, rxd, e0a, e0b, e1a, e1b;
  logic [2:0]  op = 3'h0;
  logic [1:0]  sel = 2'h0;
  logic [3:0]  dat = 4'h0, w = 4'h0, jo;
  logic [31:0] c0, c1;
  int          n_errors = 0, n_checks = 0;
  jca_aux_io #(.BOOT_CYC(4)) DUT (.CLOCK(clk), .RESET_N(rst_n), .ISO_START_IN(st),
    .ISO_RESET_IN_N(srn), .ISO_ABORT_IN(ab), .ISO_WAIT_IN_1(w[0]), .ISO_WAIT_IN_2(w[1]),
    .ISO_WAIT_IN_3(w[2]), .ISO_WAIT_IN_4(w[3]), .HW_EXCEPTION(exc), .INSTR_VALID(v),
    .INSTR_OP(op), .INSTR_SEL(sel), .INSTR_DATA(dat), .INSTR_READY(rdy), .SOFT_RESET_OUT(sro),
    .ERROR_READY_OUT_N(err_n), .JOB_ACTIVE_OUT(ja), .BUSY_OUT(bsy), .MARKING_ACTIVE_OUT(mk),
    .JOB_OUT_1(jo[0]), .JOB_OUT_2(jo[1]), .JOB_OUT_3(jo[2]), .JOB_OUT_4(jo[3]),
    .ENC0_PHASE_A_P(e0a), .ENC0_PHASE_B_P(e0b), .ENC1_PHASE_A_P(e1a), .ENC1_PHASE_B_P(e1b),
    .ENC0_COUNT(c0), .ENC1_COUNT(c1), .STEPPER_TX_DATA(txd), .STEPPER_LINK_TX_P(tp),
    .STEPPER_LINK_TX_N(tn), .STEPPER_LINK_RX_P(rp), .STEPPER_RX_DATA(rxd));
  jca_far_end u_far (.clk(clk), .run(run), .tx_p(tp), .tx_n(tn), .rx_p(rp),
    .enc0_a(e0a), .enc0_b(e0b), .enc1_a(e1a), .enc1_b(e1b));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // Held until the edge that sees ready, then one idle cycle
  task automatic issue(input logic [2:0] o, input logic [1:0] s, input logic [3:0] d);
    for (int k = 0; k < 40 && rdy !== 1'h1; k++) cyc(1);
    v = 1'h1;
    op = o;
    sel = s;
    dat = d;
    cyc(1);
    v = 1'h0;
    cyc(1);
  endtask : issue
  task automatic boot();
    for (int k = 0; k < 40 && err_n !== 1'h0; k++) cyc(1);
    chk(err_n, 1'h0);
    cyc(2);
  endtask : boot
  task automatic t_job();
    issue(`JCA_OP_OUTPUT_SET, 2'h0, 4'hf);
    chk(jo, 4'h0);
    issue(`JCA_OP_OPEN, 2'h0, 4'h0);
    chk({bsy, ja}, 2'h3);
    issue(`JCA_OP_NOP, 2'h0, 4'h0);
    issue(`JCA_OP_MARK_ON, 2'h0, 4'h0);
    chk(mk, 1'h1);
    issue(`JCA_OP_OUTPUT_SET, 2'h0, 4'ha);
    chk(jo, 4'ha);
    issue(`JCA_OP_OUTPUT_SET, 2'h0, 4'h5);
    chk(jo, 4'h5);
    issue(`JCA_OP_MARK_OFF, 2'h0, 4'h0);
    chk(mk, 1'h0);
    issue(`JCA_OP_MARK_ON, 2'h0, 4'h0);
    issue(`JCA_OP_CLOSE, 2'h0, 4'h0);
    chk({bsy, ja, mk}, 3'h0);
  endtask : t_job
  task automatic t_wait();
    issue(`JCA_OP_OPEN, 2'h0, 4'h0);
    issue(`JCA_OP_WAIT_START, 2'h0, 4'h0);
    cyc(8);
    chk({rdy, ja}, 2'h1);
    st = 1'h1;
    cyc(8);
    chk(rdy, 1'h1);
    st = 1'h0;
    for (int i = 0; i < 4; i++) begin
      issue(`JCA_OP_WAIT_IN, i[1:0], 4'h0);
      w = 4'hf ^ (4'h1 << i);
      cyc(8);
      chk(rdy, 1'h0);
      w = 4'hf;
      cyc(8);
      chk(rdy, 1'h1);
      w = 4'h0;
      cyc(4);
    end
    issue(`JCA_OP_CLOSE, 2'h0, 4'h0);
  endtask : t_wait
  task automatic t_abort();
    issue(`JCA_OP_OPEN, 2'h0, 4'h0);
    issue(`JCA_OP_MARK_ON, 2'h0, 4'h0);
    issue(`JCA_OP_OUTPUT_SET, 2'h0, 4'h9);
    issue(`JCA_OP_WAIT_IN, 2'h2, 4'h0);
    ab = 1'h1;
    cyc(10);
    ab = 1'h0;
    cyc(6);
    chk({bsy, ja, mk, rdy, jo}, 8'h19);
  endtask : t_abort
  task automatic t_exc();
    exc = 1'h1;
    cyc(2);
    chk(err_n, 1'h1);
    exc = 1'h0;
    cyc(2);
    chk(err_n, 1'h0);
  endtask : t_exc
  task automatic t_link();
    txd = 1'h1;
    cyc(10);
    chk({tp, tn, rxd}, 3'h5);
    txd = 1'h0;
    cyc(10);
    chk({tp, tn, rxd}, 3'h2);
    run = 1'h1;
    cyc(64);
    run = 1'h0;
    cyc(8);
    chk({c0[31], c0 == 32'h0, c1[31]}, 3'h1);
    chk(c0, 32'h00000010);
    chk(c1, 32'hfffffff0);
  endtask : t_link
  task automatic t_soft();
    issue(`JCA_OP_OPEN, 2'h0, 4'h0);
    issue(`JCA_OP_OUTPUT_SET, 2'h0, 4'h6);
    srn = 1'h0;
    cyc(10);
    chk({sro, err_n, bsy, ja, jo}, 8'hc0);
    srn = 1'h1;
    boot();
    chk(rdy, 1'h1);
  endtask : t_soft
  task automatic results();
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    cyc(8);
    rst_n = 1'h1;
    boot();
    t_job();
    t_wait();
    t_abort();
    t_exc();
    t_link();
    t_soft();
    results();
  end
  // About 65 times the expected run of some 300 cycles
  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule : testbench
`default_nettype wire
